// file: logic/vcp_defs.svh
// Constants for the video capture pipeline: offsets, fields, reset values.
// Assumes 32-bit classic Wishbone, byte address = 4 * register index.
`ifndef VCP_DEFS_SVH
`define VCP_DEFS_SVH
`define VCP_R_CTRL   4'h0
`define VCP_R_WIN_H  4'h1
`define VCP_R_WIN_V  4'h2
`define VCP_R_ROI_H  4'h3
`define VCP_R_ROI_V  4'h4
`define VCP_R_GAIN   4'h5
`define VCP_R_CORE   4'h6
`define VCP_R_LUT    4'h7
`define VCP_R_STAT   4'h8
`define VCP_NCFG     7
`define VCP_B_START  0
`define VCP_B_ROI    1
`define VCP_B_GAIN   2
`define VCP_B_LUT    3
`define VCP_B_HSL    4
`define VCP_B_CORE   5
`define VCP_B_HDEC   6
`define VCP_B_FMT    10
`define VCP_B_TSTART 12
`define VCP_B_TEDGE  13
`define VCP_B_TDIR   14
`define VCP_B_TLEVEL 15
`define VCP_B_TPOL   16
`define VCP_B_TSRC   17
`define VCP_B_FSEL   19
`define VCP_B_FRAME  21
`define VCP_B_STORE  22
`define VCP_B_DMA    23
`define VCP_B_CNT    16
`define VCP_B_FCNT   8
`define VCP_RST_CTRL 32'h0000_0000
`define VCP_RST_WINH 32'h0280_0000
`define VCP_RST_WINV 32'h01e0_0000
`define VCP_RST_GAIN 32'h0040_4040
`define VCP_RST_CORE 32'h0000_0110
`define VCP_NV_LAST  3'h7
`endif

// file: logic/vcp_pkg.sv
// Types for the video capture pipeline.
// Assumes vcp_defs.svh supplies the numeric constants.
package vcp_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ARM  = 4'b0010,
        ST_WAIT = 4'b0100,
        ST_CAPT = 4'b1000
    } vcp_st_t;
    typedef enum logic [1:0] {
        FMT_PACK = 2'h0,
        FMT_HUE  = 2'h1,
        FMT_SAT  = 2'h2,
        FMT_LUM  = 2'h3
    } vcp_fmt_t;
endpackage

// file: logic/vcp_top.sv
// Video capture window, decimation, colour pipeline and trigger control.
// Assumes clk_sys is the decoder pixel clock, one pixel per cycle while
// line_en is high; nonvolatile storage answers one cycle after nv_addr.
`timescale 1ns/10ps
`include "vcp_defs.svh"
module vcp_top (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Decoded video
    input  wire logic [7:0]  vid_r,
    input  wire logic [7:0]  vid_g,
    input  wire logic [7:0]  vid_b,
    input  wire logic        line_en,
    input  wire logic        frame_en,
    input  wire logic        field_odd,
    // Trigger pin
    input  wire logic        trig_i,
    output logic             trig_o,
    output logic             trig_oe,
    // Nonvolatile configuration
    output logic      [2:0]  nv_addr,
    input  wire logic [31:0] nv_data,
    // Toward frame memory
    output logic             px_valid,
    output logic      [31:0] px_data,
    output logic             px_wide,
    output logic             mem_store,
    output logic      [2:0]  dma_en,
    output logic             acq_busy
);
    import vcp_pkg::*;

    localparam logic [31:0] RST_V [0:6] = '{
        `VCP_RST_CTRL, `VCP_RST_WINH, `VCP_RST_WINV,
        `VCP_RST_WINH, `VCP_RST_WINV, `VCP_RST_GAIN,
        `VCP_RST_CORE};

    logic [31:0] cfg_r [0:6];
    logic [2:0]  boot_r;
    logic        boot_done_r;
    logic        ack_r;
    logic [31:0] dat_r;
    logic        start_r;
    vcp_st_t     st_r;
    logic [15:0] left_r;
    logic        half_r;

    // Boot load from nonvolatile storage
    wire [2:0] ld_idx = boot_r - 3'h1;
    wire       boot_ld = !boot_done_r && (boot_r != 3'h0);

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            boot_r      <= 3'h0;
            boot_done_r <= 1'b0;
        end else if (!boot_done_r) begin
            boot_r      <= boot_r + 3'h1;
            boot_done_r <= (boot_r == `VCP_NV_LAST);
        end
    end

    // Bus decode
    wire       req    = wb_cyc_i & wb_stb_i;
    wire [3:0] widx   = wb_adr_i[5:2];
    wire       wr_now = req & wb_we_i & ack_r;
    wire       cfg_hit = widx < 4'(`VCP_NCFG);
    wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                         {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            for (int i = 0; i < `VCP_NCFG; i++) begin
                cfg_r[i] <= RST_V[i];
            end
        end else begin
            for (int i = 0; i < `VCP_NCFG; i++) begin
                if (boot_ld && ld_idx == 3'(i)) begin
                    cfg_r[i] <= nv_data;
                end else if (wr_now && widx == 4'(i)) begin
                    cfg_r[i] <= (cfg_r[i] & ~bmask) |
                                (wb_dat_i & bmask);
                end
            end
        end
    end

    // Config fields
    wire [31:0] ctl      = cfg_r[0];
    wire        roi_en   = ctl[`VCP_B_ROI];
    wire        gain_en  = ctl[`VCP_B_GAIN];
    wire        lut_en   = ctl[`VCP_B_LUT];
    wire        hsl_en   = ctl[`VCP_B_HSL];
    wire        core_en  = ctl[`VCP_B_CORE];
    wire [1:0]  fmt      = ctl[`VCP_B_FMT +: 2];
    wire        t_start  = ctl[`VCP_B_TSTART];
    wire        t_rise   = ctl[`VCP_B_TEDGE];
    wire        t_dir    = ctl[`VCP_B_TDIR];
    wire        t_level  = ctl[`VCP_B_TLEVEL];
    wire        t_pol    = ctl[`VCP_B_TPOL];
    wire [1:0]  t_src    = ctl[`VCP_B_TSRC +: 2];
    wire [1:0]  fsel     = ctl[`VCP_B_FSEL +: 2];
    wire        frm_mode = ctl[`VCP_B_FRAME];
    wire [7:0]  core_thr = cfg_r[6][7:0];
    wire [15:0] fcount   = cfg_r[6][`VCP_B_FCNT +: 16];

    // Lookup table port: [7:0] index, [15:8] value, [17:16] table
    logic [7:0] lut_m [3][256];
    logic [9:0] lptr_r;
    wire  [1:0] lp_tbl = lptr_r[9:8];
    wire  [7:0] lp_rd  = (lp_tbl < 2'h3) ?
                         lut_m[lp_tbl][lptr_r[7:0]] : 8'h00;
    wire        lut_wr = wr_now && widx == `VCP_R_LUT &&
                         wb_sel_i[2] && wb_sel_i[1] && wb_sel_i[0];

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            lptr_r <= 10'h000;
        end else if (lut_wr) begin
            lptr_r <= {wb_dat_i[17:16], wb_dat_i[7:0]};
        end
    end

    // Trigger pin sampling: change counts once two late stages agree
    logic [2:0] tsy_r;
    logic       tq_r;
    logic       tq_d_r;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            tsy_r  <= 3'h0;
            tq_r   <= 1'b0;
            tq_d_r <= 1'b0;
        end else begin
            tsy_r  <= {tsy_r[1:0], trig_i};
            tq_r   <= (tsy_r[1] == tsy_r[2]) ? tsy_r[2] : tq_r;
            tq_d_r <= tq_r;
        end
    end

    wire trig_hit = t_rise ? (tq_r & ~tq_d_r)
                           : (~tq_r & tq_d_r);

    wire [31:0] stat = {left_r, 10'h000, tq_r, boot_done_r, st_r};
    wire [31:0] rd_mux =
        cfg_hit ? (cfg_r[widx[2:0]] &
                   ~(32'h1 << `VCP_B_START)) :
        (widx == `VCP_R_LUT)  ? {14'h0, lp_tbl, lp_rd,
                                 lptr_r[7:0]} :
        (widx == `VCP_R_STAT) ? stat : 32'h0000_0000;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ack_r   <= 1'b0;
            dat_r   <= 32'h0000_0000;
            start_r <= 1'b0;
        end else begin
            ack_r   <= req & ~ack_r;
            dat_r   <= (req & ~ack_r) ? rd_mux : dat_r;
            start_r <= wr_now && widx == `VCP_R_CTRL &&
                       wb_sel_i[0] && wb_dat_i[`VCP_B_START];
        end
    end

    // Line and frame position
    logic [11:0] hpos_r;
    logic [11:0] vpos_r;
    logic        le_d_r;
    logic        fe_d_r;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            hpos_r <= 12'h000;
            vpos_r <= 12'h000;
            le_d_r <= 1'b0;
            fe_d_r <= 1'b0;
        end else begin
            le_d_r <= line_en;
            fe_d_r <= frame_en;
            hpos_r <= line_en ? hpos_r + 12'h001 : 12'h000;
            if (!frame_en) begin
                vpos_r <= 12'h000;
            end else if (le_d_r && !line_en) begin
                vpos_r <= vpos_r + 12'h001;
            end
        end
    end

    wire fe_rise = frame_en & ~fe_d_r;
    wire fe_fall = ~frame_en & fe_d_r;

    // Window, region of interest and decimation per axis
    wire [11:0] ax_pos [2];
    wire        ax_ok  [2];
    assign ax_pos[0] = hpos_r;
    assign ax_pos[1] = vpos_r;

    for (genvar d = 0; d < 2; d++) begin : g_ax
        wire [11:0] w_first = cfg_r[1 + d][11:0];
        wire [11:0] w_cnt   = cfg_r[1 + d][`VCP_B_CNT +: 12];
        wire [11:0] r_first = cfg_r[3 + d][11:0];
        wire [11:0] r_cnt   = cfg_r[3 + d][`VCP_B_CNT +: 12];
        wire [1:0]  dec     = ctl[`VCP_B_HDEC + 2 * d +: 2];
        wire [12:0] w_end   = {1'b0, w_first} + {1'b0, w_cnt};
        wire [12:0] r_end   = {1'b0, r_first} + {1'b0, r_cnt};
        wire [11:0] rel     = ax_pos[d] - w_first;
        wire [11:0] off     = rel - (roi_en ? r_first : 12'h000);
        wire [2:0]  dmask   = {dec == 2'h3, dec >= 2'h2,
                               dec >= 2'h1};
        // Window bounds, then nested region kept inside the window
        wire in_w = ax_pos[d] >= w_first &&
                    {1'b0, ax_pos[d]} < w_end;
        wire in_r = !roi_en || (rel >= r_first &&
                    {1'b0, rel} < r_end);
        // Phase counted from the first kept position of the region
        wire dec_ok = (off[2:0] & dmask) == 3'h0;
        assign ax_ok[d] = in_w & in_r & dec_ok;
    end

    // Acquisition sequencing
    wire field_ok = !frm_mode || fsel == 2'h0 ||
                    (fsel == 2'h1 && field_odd) ||
                    (fsel == 2'h2 && !field_odd);
    wire keep = st_r == ST_CAPT && line_en && frame_en &&
                ax_ok[0] && ax_ok[1];
    vcp_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            ST_IDLE: if (start_r && boot_done_r) begin
                st_nxt = (t_start && !t_dir) ? ST_ARM : ST_WAIT;
            end
            ST_ARM: if (trig_hit) begin
                st_nxt = ST_WAIT;
            end
            ST_WAIT: if (fe_rise && field_ok) begin
                st_nxt = ST_CAPT;
            end
            ST_CAPT: if (fe_fall && !(frm_mode && !half_r)) begin
                st_nxt = (left_r == 16'h0001) ? ST_IDLE : ST_WAIT;
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st_r   <= ST_IDLE;
            left_r <= 16'h0000;
            half_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            if (st_r == ST_IDLE && st_nxt != ST_IDLE) begin
                left_r <= (fcount == 16'h0000) ? 16'h0001
                                               : fcount;
                half_r <= 1'b0;
            end else if (st_r == ST_CAPT && fe_fall) begin
                // A frame is two fields in frame mode
                half_r <= frm_mode & ~half_r;
                if (!(frm_mode && !half_r)) begin
                    left_r <= left_r - 16'h0001;
                end
            end
        end
    end

    // Colour pipeline: sample, gain, lookup, HSL, output
    wire [7:0] vin [3];
    assign vin[0] = vid_r;
    assign vin[1] = vid_g;
    assign vin[2] = vid_b;
    logic [7:0] s1_c_r [3];
    logic [7:0] s2_c_r [3];
    logic [7:0] s3_c_r [3];
    logic [3:0] v_r;

    for (genvar c = 0; c < 3; c++) begin : g_ch
        wire [7:0]  gk   = cfg_r[5][8 * c +: 8];
        // Gain is unsigned with six fraction bits, 64 is unity
        wire [15:0] prod = s1_c_r[c] * gk;
        wire [7:0]  gsat = (prod[15:14] != 2'h0) ? 8'hff
                                                 : prod[13:6];
        always_ff @(posedge clk_sys) begin
            if (!nrst) begin
                s1_c_r[c] <= 8'h00;
                s2_c_r[c] <= 8'h00;
                s3_c_r[c] <= 8'h00;
                for (int i = 0; i < 256; i++) begin
                    lut_m[c][i] <= 8'(i);
                end
            end else begin
                s1_c_r[c] <= vin[c];
                s2_c_r[c] <= gain_en ? gsat : s1_c_r[c];
                s3_c_r[c] <= lut_en ? lut_m[c][s2_c_r[c]]
                                    : s2_c_r[c];
                if (lut_wr && wb_dat_i[17:16] == 2'(c)) begin
                    lut_m[c][wb_dat_i[7:0]] <= wb_dat_i[15:8];
                end
            end
        end
    end

    wire [7:0] cr = s3_c_r[0];
    wire [7:0] cg = s3_c_r[1];
    wire [7:0] cb = s3_c_r[2];
    wire [7:0] mx = (cr >= cg && cr >= cb) ? cr :
                    (cg >= cb) ? cg : cb;
    wire [7:0] mn = (cr <= cg && cr <= cb) ? cr :
                    (cg <= cb) ? cg : cb;
    wire [7:0] dl = mx - mn;
    // 77/150/29 over 256 approximates the luminance weights
    wire [15:0] lsum = 16'(cr * 8'd77) + 16'(cg * 8'd150) +
                       16'(cb * 8'd29);
    wire [9:0]  sum3 = {2'h0, cr} + {2'h0, cg} + {2'h0, cb};
    wire [17:0] mn3  = 18'(mn * 10'd765);
    wire [17:0] sq   = (sum3 == 10'h000) ? 18'h3fff_f
                                         : mn3 / {8'h00, sum3};
    wire [7:0]  sat  = (sum3 == 10'h000) ? 8'h00
                                         : 8'(18'd255 - sq);
    // Hexcone hue in 1/6 turn sectors of 43 codes
    wire        hr   = mx == cr;
    wire        hg   = !hr && mx == cg;
    wire [7:0]  na   = hr ? cg : hg ? cb : cr;
    wire [7:0]  nb   = hr ? cb : hg ? cr : cg;
    wire [7:0]  mag  = (na >= nb) ? na - nb : nb - na;
    wire [7:0]  base = hr ? 8'd0 : hg ? 8'd85 : 8'd171;
    wire [13:0] hnum = 14'(mag * 6'd43);
    wire [13:0] hq   = (dl == 8'h00) ? 14'h0000
                                     : hnum / {6'h00, dl};
    wire [7:0]  hue  = (dl == 8'h00) ? 8'h00 :
                       (na >= nb) ? base + hq[7:0]
                                  : base - hq[7:0];
    wire        cored = core_en && sat < core_thr;

    logic [7:0] s4_h_r;
    logic [7:0] s4_s_r;
    logic [7:0] s4_l_r;
    logic [23:0] s4_rgb_r;
    logic        px_valid_r;
    logic [31:0] px_data_r;
    logic        px_wide_r;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            v_r      <= 4'h0;
            s4_h_r   <= 8'h00;
            s4_s_r   <= 8'h00;
            s4_l_r   <= 8'h00;
            s4_rgb_r <= 24'h000000;
        end else begin
            v_r      <= {v_r[2:0], keep};
            s4_h_r   <= cored ? 8'h00 : hue;
            s4_s_r   <= sat;
            s4_l_r   <= lsum[15:8];
            s4_rgb_r <= {cr, cg, cb};
        end
    end

    wire [23:0] pack = hsl_en ? {s4_h_r, s4_s_r, s4_l_r}
                              : s4_rgb_r;
    wire [31:0] px_nxt =
        (fmt == FMT_PACK) ? {8'h00, pack} :
        (fmt == FMT_HUE)  ? {24'h0, s4_h_r} :
        (fmt == FMT_SAT)  ? {24'h0, s4_s_r} :
                            {24'h0, s4_l_r};

    // Trigger pin drive and other outputs
    wire t_stat = (t_src == 2'h0) ? t_level :
                  (t_src == 2'h1) ? (st_r != ST_IDLE) :
                  (t_src == 2'h2) ? (st_r == ST_CAPT) :
                                    (st_r == ST_ARM);
    logic trig_o_r;
    logic trig_oe_r;
    logic mem_store_r;
    logic [2:0] dma_en_r;
    logic acq_busy_r;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            px_valid_r  <= 1'b0;
            px_data_r   <= 32'h0000_0000;
            px_wide_r   <= 1'b0;
            trig_o_r    <= 1'b0;
            trig_oe_r   <= 1'b0;
            mem_store_r <= 1'b0;
            dma_en_r    <= 3'h0;
            acq_busy_r  <= 1'b0;
        end else begin
            px_valid_r  <= v_r[3];
            px_data_r   <= px_nxt;
            px_wide_r   <= fmt == FMT_PACK;
            trig_o_r    <= t_stat ^ t_pol;
            trig_oe_r   <= t_dir;
            mem_store_r <= ctl[`VCP_B_STORE];
            dma_en_r    <= ctl[`VCP_B_DMA +: 3];
            acq_busy_r  <= st_r != ST_IDLE;
        end
    end

    assign wb_ack_o  = ack_r;
    assign wb_dat_o  = dat_r;
    assign nv_addr   = boot_r;
    assign px_valid  = px_valid_r;
    assign px_data   = px_data_r;
    assign px_wide   = px_wide_r;
    assign trig_o    = trig_o_r;
    assign trig_oe   = trig_oe_r;
    assign mem_store = mem_store_r;
    assign dma_en    = dma_en_r;
    assign acq_busy  = acq_busy_r;

    default clocking cb_sys @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    // Forward form avoids looking back past the start of the run
    property p_keep_out;
        keep |-> ##5 px_valid_r;
    endproperty
    a_keep_out: assert property (p_keep_out)
        else $error("pixel valid does not follow keep");

    property p_drop_out;
        !keep |-> ##5 !px_valid_r;
    endproperty
    a_drop_out: assert property (p_drop_out)
        else $error("pixel valid without a kept pixel");

    property p_pack_top;
        px_valid_r && px_wide_r |-> px_data_r[31:24] == 8'h00;
    endproperty
    a_pack_top: assert property (p_pack_top)
        else $error("packed top byte not zero");

    property p_plane;
        px_valid_r && !px_wide_r |-> px_data_r[31:8] == 24'h0;
    endproperty
    a_plane: assert property (p_plane)
        else $error("plane word has upper bits set");

    property p_core;
        $past(core_en) && s4_s_r < $past(core_thr) |->
            s4_h_r == 8'h00;
    endproperty
    a_core: assert property (p_core)
        else $error("hue not cleared under threshold");

    property p_lum;
        s4_l_r == 8'((16'($past(cr) * 8'd77) +
                      16'($past(cg) * 8'd150) +
                      16'($past(cb) * 8'd29)) >> 8);
    endproperty
    a_lum: assert property (p_lum)
        else $error("luminance mismatch");

    sequence s_armed_hit;
        st_r == ST_ARM ##0 trig_hit;
    endsequence
    property p_trig;
        s_armed_hit |=> st_r == ST_WAIT;
    endproperty
    a_trig: assert property (p_trig)
        else $error("trigger edge did not arm capture");

    property p_start;
        st_r == ST_IDLE && start_r && boot_done_r |=>
            st_r != ST_IDLE ##1 acq_busy_r;
    endproperty
    a_start: assert property (p_start)
        else $error("start did not begin acquisition");

    property p_boot;
        !boot_done_r |-> st_r == ST_IDLE;
    endproperty
    a_boot: assert property (p_boot)
        else $error("acquisition before configuration load");

    property p_trig_out;
        ##1 trig_oe_r == $past(t_dir) &&
        ($past(t_src) != 2'h0 ||
         trig_o_r == ($past(t_level) ^ $past(t_pol)));
    endproperty
    a_trig_out: assert property (p_trig_out)
        else $error("trigger drive mismatch");
endmodule

// file: sim/tb_video_capture_window_pipeline.sv
// Bench for the capture pipeline: boot from a model store, then captures.
// Assumes vcp_vid_src feeds video and the bench is the Wishbone master.
`timescale 1ns/10ps
`include "vcp_defs.svh"
module tb_video_capture_window_pipeline;
    import vcp_pkg::*;
    localparam logic [31:0] NV [0:7] = '{32'h0, 32'h0004_0002,
        32'h0002_0001, 32'h0004_0000, 32'h0002_0000, 32'h0040_4040,
        32'h0000_0110, 32'h0};
    logic              clk_sys = 1'b0;
    logic              nrst = 1'b0;
    logic              cyc = 1'b0;
    logic              we = 1'b0;
    logic              go = 1'b0;
    logic              trig = 1'b0;
    logic        [5:0] adr = 6'h0;
    logic       [31:0] dat = 32'h0;
    logic       [31:0] q;
    logic       [31:0] nv_data = 32'h0;
    logic       [31:0] wb_dat_o, px_data;
    logic        [7:0] vid_r, vid_g, vid_b;
    logic        [2:0] nv_addr, dma_en;
    logic              wb_ack_o, trig_o, trig_oe, px_valid, px_wide;
    logic              mem_store, acq_busy, line_en, frame_en, field_odd;
    logic              src_done;
    logic       [32:0] got_q[$];
    int                fails = 0;
    int                total_checks = 0;
    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) nv_data <= NV[nv_addr];
    always @(posedge clk_sys) if (px_valid === 1'b1)
        got_q.push_back({px_wide, px_data});
    vcp_vid_src SRC (.clk_sys(clk_sys), .go(go), .done(src_done),
        .vid_r(vid_r), .vid_g(vid_g), .vid_b(vid_b), .line_en(line_en),
        .frame_en(frame_en), .field_odd(field_odd));
    vcp_top DUT (.clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .vid_r(vid_r), .vid_g(vid_g), .vid_b(vid_b), .line_en(line_en),
        .frame_en(frame_en), .field_odd(field_odd), .trig_i(trig),
        .trig_o(trig_o), .trig_oe(trig_oe), .nv_addr(nv_addr),
        .nv_data(nv_data), .px_valid(px_valid), .px_data(px_data),
        .px_wide(px_wide), .mem_store(mem_store), .dma_en(dma_en),
        .acq_busy(acq_busy));
    task automatic test_done();
        if (fails == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [5:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n == 20) fails++;
        q = wb_dat_o;
        cyc <= 1'b0;
    endtask
    // Expected words come from the window, region and decimation settings
    task automatic run(input logic [31:0] ctl, input logic [31:0] roih);
        int n, rh, rc;
        logic [32:0] e;
        wb(1'b1, 6'h0c, roih);
        wb(1'b1, 6'h00, ctl | 32'h1);
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        n = 0;
        while (src_done !== 1'b1 && n < 500) begin
            @(posedge clk_sys);
            n++;
        end
        if (n == 500) fails++;
        repeat (8) @(posedge clk_sys);
        chk({32'h0, acq_busy}, 33'h0);
        rc = ctl[1] ? int'(roih[27:16]) : 4;
        for (int v = 0; v < 4; v++) for (int h = 0; h < 8; h++) begin
            rh = h - 2 - (ctl[1] ? int'(roih[11:0]) : 0);
            if (h >= 2 && h < 6 && v >= 1 && v < 3 && rh >= 0 && rh < rc
                && rh % (1 << ctl[7:6]) == 0
                && (v - 1) % (1 << ctl[9:8]) == 0) begin
                if (ctl[11:10] == FMT_LUM)
                    e = {25'h0, 8'((77 * h + 150 * v + 29 * 90) >> 8)};
                else
                    e = {9'h100, 8'(h), 8'(v), 8'h5a};
                chk(got_q.size() ? got_q.pop_front() : 33'h0, e);
            end
        end
        chk({1'b0, 32'(got_q.size())}, 33'h0);
    endtask
    initial begin
        #400000;
        fails++;
        test_done();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (10) @(posedge clk_sys);
        wb(1'b0, 6'h04, 32'h0);
        chk({1'b0, q}, {1'b0, NV[1]});
        wb(1'b0, 6'h20, 32'h0);
        chk({27'h0, q[5:0]}, 33'h11);
        wb(1'b0, 6'h24, 32'h0);
        chk({1'b0, q}, 33'h0);
        wb(1'b1, 6'h00, 32'h03c1_c000);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, trig_oe, trig_o}, 33'h2);
        chk({29'h0, mem_store, dma_en}, 33'hf);
        wb(1'b1, 6'h00, 32'h0002_c000);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, trig_oe, trig_o}, 33'h2);
        // Arm on a rising trigger edge; the next run then captures
        wb(1'b1, 6'h00, 32'h0000_3001);
        wb(1'b0, 6'h20, 32'h0);
        chk({29'h0, q[3:0]}, 33'h2);
        trig <= 1'b1;
        repeat (8) @(posedge clk_sys);
        wb(1'b0, 6'h20, 32'h0);
        chk({27'h0, q[5:0]}, 33'h34);
        run(32'h0, 32'h0004_0000);
        run(32'h142, 32'h0003_0001);
        run(32'hc00, 32'h0004_0000);
        test_done();
    end
endmodule

// file: sim/vcp_vid_src.sv
// Video source model: one field of 4 lines by 8 pixels for each go pulse.
// Assumes the capture block samples all video signals on rising clk_sys.
`timescale 1ns/10ps
module vcp_vid_src (
    // Clock and control
    input  wire logic       clk_sys,
    input  wire logic       go,
    output logic            done,
    // Video
    output logic      [7:0] vid_r,
    output logic      [7:0] vid_g,
    output logic      [7:0] vid_b,
    output logic            line_en,
    output logic            frame_en,
    output logic            field_odd
);
    // Blanking carries a toggling pattern so no stale pixel looks valid
    task automatic blank(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            {vid_r, vid_g, vid_b} <= ~{vid_r, vid_g, vid_b};
        end
    endtask
    initial begin
        {done, line_en, frame_en, field_odd} = 4'h0;
        {vid_r, vid_g, vid_b} = 24'h0;
        forever begin
            blank(1);
            if (go === 1'b1) begin
                blank(3);
                frame_en <= 1'b1;
                field_odd <= 1'b1;
                for (int v = 0; v < 4; v++) begin
                    blank(3);
                    for (int h = 0; h < 8; h++) begin
                        @(posedge clk_sys);
                        line_en <= 1'b1;
                        vid_r <= 8'(h);
                        vid_g <= 8'(v);
                        vid_b <= 8'h5a;
                    end
                    @(posedge clk_sys);
                    line_en <= 1'b0;
                end
                blank(2);
                frame_en <= 1'b0;
                done <= 1'b1;
                blank(1);
                done <= 1'b0;
            end
        end
    end
endmodule
